/* rtl/auto_dial_bit_port.sv */
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Dialer writes set one bit of an eight-entry latch, enabled by secondary select.
// RULE2 - Dialer reads pick one bit via an eight-input selector, enabled by select.
// RULE3 - Buffered I/O reset clears the output latch, making all dialer outputs inactive.
// RULE4 - The selected bit returns to the host on the serial input line, buffered.
// RULE5 - The five dialer status inputs are inverted before the selector.
// RULE6 - The six latched dialer outputs are inverted before being driven out.
// RULE7 - Channel interrupt request is routed to exactly one of eight system levels.
// RULE8 - Base match, aux select, address bit ten and strobe high enable the latch.
// RULE9 - Base match, aux select, address bit ten high, strobe low enable the selector.
// RULE10 - Dialer reachable only on base match with controller-select line low.
// RULE11 - Low three bit-address lines pick the entry; written value comes from serial out.
`include "auto_dial_defs.svh"

module auto_dial_bit_port
	import auto_dial_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        ce,
	// Bit bus
	input  wire logic        chanABaseMatch,
	input  wire logic        controllerSelectAddrN,
	input  wire logic        addrBitTen,
	input  wire logic [2:0]  bitbusBitAddr,
	input  wire logic        bitbusBitStrobe,
	input  wire logic        bitbusSerialOut,
	output logic             bitbusSerialIn,
	output logic             bitbusSerialInOeN,
	input  wire logic        bufferedIoResetN,
	// Dialer status lines
	input  wire logic        lineOccupiedIn,
	input  wire logic        nextDigitRequestIn,
	input  wire logic        abandonRetryIn,
	input  wire logic        setStatusIn,
	input  wire logic        powerIndicationIn,
	// Dialer control lines
	output logic             callRequestOut,
	output logic             digitPresentOut,
	output logic             digitW8Out,
	output logic             digitW4Out,
	output logic             digitW2Out,
	output logic             digitW1Out,
	// Interrupt routing
	input  wire logic        chanIrqN,
	output logic [7:0]       sysIrqLevelN,
	output logic             irq,
	// AXI4-Lite slave
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	state_t s_q;
	state_t s_d;

	// ----------------------------------------------------------------
	// Select decode
	// ----------------------------------------------------------------
	logic       auxSel;
	logic       writeEn;
	logic       readEn;
	logic [4:0] insInv;
	logic [7:0] selData;

	// Aux select only with base match and controller line low
	assign auxSel  = chanABaseMatch && !controllerSelectAddrN;   // see RULE10
	assign writeEn = auxSel && addrBitTen && bitbusBitStrobe;    // see RULE8
	assign readEn  = auxSel && addrBitTen && !bitbusBitStrobe;   // see RULE9

	// Status lines inverted on the way into the selector
	assign insInv = ~{powerIndicationIn, setStatusIn, abandonRetryIn,
		nextDigitRequestIn, lineOccupiedIn};                      // see RULE5

	// Selector inputs; top three read as zero
	assign selData = {3'h0, insInv};

	// ----------------------------------------------------------------
	// Register access helpers
	// ----------------------------------------------------------------
	logic        doWrite;
	logic        wrCtrl;
	logic        wrEvent;
	logic        wrMask;
	logic        wrHit;
	logic        doRead;
	logic [31:0] rdValue;
	logic        rdHit;
	logic [4:0]  evtSet;
	logic [4:0]  evtClr;

	// A write completes once address and data are both held
	assign doWrite = s_q.awHeld && s_q.wHeld && !s_q.bValid;
	assign wrCtrl  = doWrite && (s_q.awAddr == `AD_OFS_CTRL);
	assign wrEvent = doWrite && (s_q.awAddr == `AD_OFS_EVENT);
	assign wrMask  = doWrite && (s_q.awAddr == `AD_OFS_MASK);
	assign wrHit   = wrCtrl || wrEvent || wrMask ||
		(s_q.awAddr == `AD_OFS_STATUS);
	assign doRead  = arvalid && arready;

	// Read data selection
	always_comb begin
		rdValue = 32'h0;
		rdHit   = 1'b1;
		case (araddr)
			`AD_OFS_CTRL: begin
				rdValue[`AD_IRQSEL_W-1:0] = s_q.irqSel;
			end
			`AD_OFS_STATUS: begin
				rdValue[7:0] = s_q.latch;
				rdValue[`AD_STAT_INS_LSB +: 5] = insInv;
				rdValue[`AD_STAT_IRQ_BIT] = !chanIrqN;
			end
			`AD_OFS_EVENT: begin
				rdValue[`AD_EVT_W-1:0] = s_q.event_;
			end
			`AD_OFS_MASK: begin
				rdValue[`AD_EVT_W-1:0] = s_q.mask;
			end
			default: begin
				rdHit = 1'b0;
			end
		endcase
	end

	// Event sources; edge pulses, except the write event, which follows writeEn for as long as it is high
	always_comb begin
		evtSet = 5'h0;
		evtSet[`AD_EVT_WRITE]   = writeEn;
		evtSet[`AD_EVT_READ]    = readEn && !s_q.readEnPrev;
		evtSet[`AD_EVT_DIGIT]   = insInv[1] && !s_q.insPrev[1];
		evtSet[`AD_EVT_ABANDON] = insInv[2] && !s_q.insPrev[2];
		evtSet[`AD_EVT_CHANIRQ] = !chanIrqN && s_q.chanIrqPrev;
		evtClr = 5'h0;
		if (wrEvent && s_q.wStrb[0]) begin
			evtClr = s_q.wData[`AD_EVT_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;

		// Output latch: reset clears, else strobe writes one entry
		if (!bufferedIoResetN) begin
			s_d.latch = `AD_LATCH_RST;                      // see RULE3
		end else if (writeEn) begin
			s_d.latch[bitbusBitAddr] = bitbusSerialOut;     // see RULE1 RULE11
		end

		// Dialer lines are the inverse of the latch
		s_d.dialOut = ~{s_d.latch[ENT_DIGIT_W1], s_d.latch[ENT_DIGIT_W2],
			s_d.latch[ENT_DIGIT_W4], s_d.latch[ENT_DIGIT_W8],
			s_d.latch[ENT_DIGIT_PRES], s_d.latch[ENT_CALL_REQ]}; // see RULE6

		// Selector drives the serial input line only while read-enabled
		s_d.serialIn    = readEn ? selData[bitbusBitAddr] : 1'b0; // see RULE2 RULE4
		s_d.serialInOeN = !readEn;                                 // see RULE4

		// One system level carries the channel request
		for (int i = 0; i < 8; i++) begin
			s_d.irqLevelN[i] = !((s_q.irqSel == 3'(i)) && !chanIrqN); // see RULE7
		end

		// Edge history
		s_d.readEnPrev  = readEn;
		s_d.insPrev     = insInv;
		s_d.chanIrqPrev = chanIrqN;

		// Sticky events: a set in the clearing cycle survives
		s_d.event_ = (s_q.event_ & ~evtClr) | evtSet;

		// Control and mask writes
		if (wrCtrl && s_q.wStrb[0]) begin
			s_d.irqSel = s_q.wData[`AD_IRQSEL_W-1:0];
		end
		if (wrMask && s_q.wStrb[0]) begin
			s_d.mask = s_q.wData[`AD_EVT_W-1:0];
		end

		// Write address and data captured independently
		if (awvalid && awready) begin
			s_d.awHeld = 1'b1;
			s_d.awAddr = awaddr;
		end
		if (wvalid && wready) begin
			s_d.wHeld = 1'b1;
			s_d.wData = wdata;
			s_d.wStrb = wstrb;
		end
		if (doWrite) begin
			s_d.awHeld = 1'b0;
			s_d.wHeld  = 1'b0;
			s_d.bValid = 1'b1;
			s_d.bResp  = wrHit ? `AD_RESP_OKAY : `AD_RESP_SLVERR;
		end else if (s_q.bValid && bready) begin
			s_d.bValid = 1'b0;
		end

		// Read answer one cycle after the address is taken
		if (doRead) begin
			s_d.rValid = 1'b1;
			s_d.rData  = rdValue;
			s_d.rResp  = rdHit ? `AD_RESP_OKAY : `AD_RESP_SLVERR;
		end else if (s_q.rValid && rready) begin
			s_d.rValid = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_q             <= '0;
			s_q.latch       <= `AD_LATCH_RST;
			s_q.dialOut     <= 6'h3f;
			s_q.serialInOeN <= 1'b1;
			s_q.irqLevelN   <= 8'hff;
			s_q.insPrev     <= 5'h1f;
			s_q.chanIrqPrev <= 1'b1;
			s_q.irqSel      <= `AD_IRQSEL_RST;
			s_q.mask        <= `AD_MASK_RST;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Bus handshakes; all idle while frozen so no transfer is taken and then lost
	assign awready = ce && !s_q.awHeld && !s_q.bValid;
	assign wready  = ce && !s_q.wHeld && !s_q.bValid;
	assign arready = ce && !s_q.rValid;
	assign bvalid  = ce && s_q.bValid;
	assign bresp   = s_q.bResp;
	assign rvalid  = ce && s_q.rValid;
	assign rdata   = s_q.rData;
	assign rresp   = s_q.rResp;

	// Bit bus and dialer pins
	assign bitbusSerialIn    = s_q.serialIn;
	assign bitbusSerialInOeN = s_q.serialInOeN;
	assign callRequestOut    = s_q.dialOut[0];
	assign digitPresentOut   = s_q.dialOut[1];
	assign digitW8Out        = s_q.dialOut[2];
	assign digitW4Out        = s_q.dialOut[3];
	assign digitW2Out        = s_q.dialOut[4];
	assign digitW1Out        = s_q.dialOut[5];

	// Interrupts
	assign sysIrqLevelN = s_q.irqLevelN;
	assign irq          = |(s_q.event_ & s_q.mask);

endmodule

/* inc/auto_dial_defs.svh */
`ifndef AUTO_DIAL_DEFS_SVH
`define AUTO_DIAL_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define AD_OFS_CTRL      8'h00
`define AD_OFS_STATUS    8'h04
`define AD_OFS_EVENT     8'h08
`define AD_OFS_MASK      8'h0c

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define AD_IRQSEL_W      3
`define AD_EVT_W         5
`define AD_EVT_WRITE     0
`define AD_EVT_READ      1
`define AD_EVT_DIGIT     2
`define AD_EVT_ABANDON   3
`define AD_EVT_CHANIRQ   4
`define AD_STAT_INS_LSB  8
`define AD_STAT_IRQ_BIT  13

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AD_IRQSEL_RST    3'h0
`define AD_MASK_RST      5'h00
`define AD_LATCH_RST     8'h00

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define AD_RESP_OKAY     2'h0
`define AD_RESP_SLVERR   2'h2

`endif

/* inc/auto_dial_pkg.sv */
package auto_dial_pkg;

	// Latch entries that drive the dialer
	typedef enum logic [2:0] {
		ENT_CALL_REQ   = 3'b000,
		ENT_DIGIT_PRES = 3'b001,
		ENT_DIGIT_W8   = 3'b010,
		ENT_DIGIT_W4   = 3'b011,
		ENT_DIGIT_W2   = 3'b100,
		ENT_DIGIT_W1   = 3'b101
	} latch_entry_t;

	// Whole state of the port
	typedef struct packed {
		logic [7:0]  latch;
		logic [5:0]  dialOut;
		logic        serialIn;
		logic        serialInOeN;
		logic [7:0]  irqLevelN;
		logic        readEnPrev;
		logic [4:0]  insPrev;
		logic        chanIrqPrev;
		logic [2:0]  irqSel;
		logic [4:0]  event_;
		logic [4:0]  mask;
		logic        awHeld;
		logic        wHeld;
		logic [7:0]  awAddr;
		logic [31:0] wData;
		logic [3:0]  wStrb;
		logic        bValid;
		logic [1:0]  bResp;
		logic        rValid;
		logic [31:0] rData;
		logic [1:0]  rResp;
	} state_t;

endpackage

/* tb/auto_dial_bit_port_properties.sv */
`timescale 1ns/1ps
module auto_dial_bit_port_properties (
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic       ce,
	input wire logic       chanABaseMatch,
	input wire logic       controllerSelectAddrN,
	input wire logic       addrBitTen,
	input wire logic [2:0] bitbusBitAddr,
	input wire logic       bitbusBitStrobe,
	input wire logic       bitbusSerialOut,
	input wire logic       bitbusSerialIn,
	input wire logic       bitbusSerialInOeN,
	input wire logic       bufferedIoResetN,
	input wire logic       lineOccupiedIn,
	input wire logic       callRequestOut,
	input wire logic       digitPresentOut,
	input wire logic       digitW8Out,
	input wire logic       digitW4Out,
	input wire logic       digitW2Out,
	input wire logic       digitW1Out,
	input wire logic       chanIrqN,
	input wire logic [7:0] sysIrqLevelN
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// Dialer decode and output pins in entry order
	wire       sel  = ce && chanABaseMatch && !controllerSelectAddrN && addrBitTen;
	wire [5:0] outs = {digitW1Out, digitW2Out, digitW4Out, digitW8Out, digitPresentOut,
		callRequestOut};
	a_write_latch: assert property (sel && bitbusBitStrobe && bufferedIoResetN && bitbusBitAddr < 3'h6
		|=> outs[$past(bitbusBitAddr)] == !$past(bitbusSerialOut)) else $error("latch write lost");
	a_read_enable: assert property (sel && !bitbusBitStrobe |=> !bitbusSerialInOeN)
		else $error("read not driven");
	a_read_value: assert property (sel && !bitbusBitStrobe && bitbusBitAddr == 3'h0
		|=> bitbusSerialIn == !$past(lineOccupiedIn)) else $error("read value wrong");
	a_read_release: assert property (ce && !(sel && !bitbusBitStrobe) |=> bitbusSerialInOeN)
		else $error("serial in not released");
	a_latch_clear: assert property (ce && !bufferedIoResetN |=> outs == 6'h3f)
		else $error("latch not cleared");
	a_deselect_hold: assert property (!sel && bufferedIoResetN |=> $stable(outs))
		else $error("unselected write took effect");
	a_irq_single: assert property ($countones(~sysIrqLevelN) <= 1)
		else $error("several levels driven");
	a_irq_route: assert property (!chanIrqN [*3] |-> sysIrqLevelN != 8'hff)
		else $error("request not routed");
	a_irq_idle: assert property (chanIrqN [*3] |-> sysIrqLevelN == 8'hff)
		else $error("level low without request");
	cover property (sel && bitbusBitStrobe);
	cover property (sel && !bitbusBitStrobe);
	cover property (!chanIrqN);
endmodule
bind auto_dial_bit_port auto_dial_bit_port_properties chk (.*);

/* tb/auto_dial_host_model.sv */
`timescale 1ns/1ps
module auto_dial_host_model (
	input  wire logic mclk,
	input  wire logic bitbusSerialIn,
	input  wire logic bitbusSerialInOeN,
	output logic       chanABaseMatch,
	output logic       controllerSelectAddrN,
	output logic       addrBitTen,
	output logic [2:0] bitbusBitAddr,
	output logic       bitbusBitStrobe,
	output logic       bitbusSerialOut,
	output logic [4:0] stat
);
	logic tenLevel;
	// Idle bus and quiet dialer at time zero
	initial begin
		tenLevel = 1'b1;
		{chanABaseMatch, addrBitTen, bitbusBitStrobe, bitbusSerialOut} = 4'h0;
		controllerSelectAddrN = 1'b1;
		bitbusBitAddr = 3'h0;
		stat = 5'h00;
	end
	// Dialer status lines
	task setStat(input logic [4:0] s);
		stat <= s;
	endtask
	// Level of address bit ten for the following accesses
	task setTen(input logic t);
		tenLevel = t;
	endtask
	// Address one bit of the channel
	task drive(input logic [2:0] a, input logic v, input logic ctl, input logic stb);
		chanABaseMatch <= 1'b1;
		controllerSelectAddrN <= ctl;
		addrBitTen <= tenLevel;
		bitbusBitAddr <= a;
		bitbusSerialOut <= v;
		bitbusBitStrobe <= stb;
		@(posedge mclk);
		chanABaseMatch <= 1'b0;
		bitbusBitStrobe <= 1'b0;
		bitbusSerialOut <= !v;
		bitbusBitAddr <= ~a;
	endtask
	task bitWrite(input logic [2:0] a, input logic v, input logic ctl);
		drive(a, v, ctl, 1'b1);
	endtask
	// A released serial in reads as unknown
	task bitRead(input logic [2:0] a, output logic v);
		drive(a, 1'b0, 1'b0, 1'b0);
		@(negedge mclk);
		v = bitbusSerialInOeN ? 1'bx : bitbusSerialIn;
		@(posedge mclk);
	endtask
endmodule

/* tb/auto_dial_bit_port_bench.sv */
`timescale 1ns/1ps
`include "auto_dial_defs.svh"
module auto_dial_bit_port_bench import auto_dial_pkg::*;;
	logic mclk, resetn, ce, chanABaseMatch, controllerSelectAddrN, addrBitTen, bitbusBitStrobe;
	logic bitbusSerialOut, bitbusSerialIn, bitbusSerialInOeN, bufferedIoResetN, chanIrqN, irq, v;
	logic callRequestOut, digitPresentOut, digitW8Out, digitW4Out, digitW2Out, digitW1Out;
	logic [2:0] bitbusBitAddr;
	logic [4:0] stat;
	logic [7:0] sysIrqLevelN, awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int failures, nTests;
	wire [5:0] outs = {digitW1Out, digitW2Out, digitW4Out, digitW8Out, digitPresentOut,
		callRequestOut};
	auto_dial_bit_port dut (.*, .lineOccupiedIn(stat[0]), .nextDigitRequestIn(stat[1]),
		.abandonRetryIn(stat[2]), .setStatusIn(stat[3]), .powerIndicationIn(stat[4]));
	auto_dial_host_model host (.*);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("Compares %0d, mismatches %0d", nTests, failures);
		if (failures == 0 && nTests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Register write, both channels offered together
	task axw(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge mclk);
			aw = awvalid && awready; w = wvalid && wready; b = bvalid; rs = bresp;
			@(posedge mclk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	// Register read
	task axr(input logic [7:0] a);
		logic ar, r;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		r = 1'b0;
		while (!r) begin
			@(negedge mclk);
			ar = arvalid && arready; r = rvalid; rd = rdata; rs = rresp;
			@(posedge mclk);
			if (ar) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	// Writes to each of the six dialer entries, then two deselected writes, then clear racing a write
	task t_latch;
		logic [5:0] e;
		e = 6'h3f;
		check(outs, e);
		for (int k = 0; k < 6; k++) begin
			host.bitWrite(3'(k), 1'b1, 1'b0);
			e[k] = 1'b0;
			@(negedge mclk);
			check(outs, e);
			@(posedge mclk);
		end
		axr(`AD_OFS_STATUS);
		check(rd[7:0], 8'h3f);
		check(rd[13:8], 6'h1f);
		host.bitWrite(3'h0, 1'b0, 1'b1);
		@(negedge mclk);
		check(outs, 6'h00);
		@(posedge mclk);
		host.setTen(1'b0);
		host.bitWrite(3'h0, 1'b0, 1'b0);
		host.setTen(1'b1);
		@(negedge mclk);
		check(outs, 6'h00);
		@(posedge mclk);
		bufferedIoResetN <= 1'b0;
		host.bitWrite(3'h1, 1'b0, 1'b0);
		bufferedIoResetN <= 1'b1;
		@(negedge mclk);
		check(outs, 6'h3f);
		@(posedge mclk);
		$display("latch test done");
	endtask
	// Every status input against every selector input
	task t_read;
		for (int k = 0; k < 5; k++) begin
			host.setStat(5'h1 << k);
			for (int j = 0; j < 8; j++) begin
				host.bitRead(3'(j), v);
				check(v, (j < 5) && (j != k));
			end
		end
		$display("read test done");
	endtask
	// Routing to each level, then raise, mask and clear the interrupt
	task t_irq;
		for (int k = 0; k < 8; k++) begin
			axw(`AD_OFS_CTRL, k);
			check(rs, `AD_RESP_OKAY);
			axr(`AD_OFS_CTRL);
			check(rd, k);
			chanIrqN <= 1'b0;
			repeat (3) @(posedge mclk);
			check(sysIrqLevelN, 8'(~(8'h1 << k)));
			chanIrqN <= 1'b1;
			repeat (3) @(posedge mclk);
			check(sysIrqLevelN, 8'hff);
		end
		check(irq, 1'b0);
		axr(`AD_OFS_EVENT);
		check(rd, 32'h1f);
		axw(`AD_OFS_MASK, 32'h10);
		@(negedge mclk);
		check(irq, 1'b1);
		@(posedge mclk);
		axw(`AD_OFS_EVENT, 32'h1f);
		@(negedge mclk);
		check(irq, 1'b0);
		@(posedge mclk);
		axr(`AD_OFS_EVENT);
		check(rd, 32'h0);
		@(posedge mclk);
		axr(8'h40);
		check(rs, `AD_RESP_SLVERR);
		$display("irq test done");
	endtask
	initial begin
		{resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{ce, bufferedIoResetN, chanIrqN} = 3'h7;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		failures = 0;
		nTests = 0;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		check(sysIrqLevelN, 8'hff);
		t_latch;
		t_read;
		t_irq;
		end_sim;
	end
	// Watchdog
	initial begin
		#200000;
		failures++;
		end_sim;
	end
endmodule
